/* File: hdl/cpc_pkg.sv */
// shared constants and types of the cpu core register block
package cpc_pkg;
   // avalon word offsets, byte addresses
   localparam logic [7:0] OFF_IP    = 8'h00;
   localparam logic [7:0] OFF_ACC   = 8'h04;
   localparam logic [7:0] OFF_TACC  = 8'h08;
   localparam logic [7:0] OFF_IDX   = 8'h0C;
   localparam logic [7:0] OFF_XPTR  = 8'h10;
   localparam logic [7:0] OFF_STK   = 8'h14;
   localparam logic [7:0] OFF_PSW   = 8'h18;
   localparam logic [7:0] OFF_ALU   = 8'h1C;
   localparam logic [7:0] OFF_PROBE = 8'h20;
   localparam logic [7:0] OFF_REGN  = 8'h24;
   localparam logic [7:0] OFF_GADR  = 8'h28;
   localparam logic [7:0] OFF_GPR   = 8'h40;
   localparam logic [7:0] OFF_GEND  = 8'h5C;
   // dedicated register indices
   localparam int         NREG     = 7;
   localparam logic [2:0] IDX_ACC  = 3'h1;
   localparam logic [2:0] IDX_PSW  = 3'h6;
   // status word layout
   localparam int         BIT_C    = 0;
   localparam int         BIT_V    = 1;
   localparam int         BIT_Z    = 2;
   localparam int         BIT_N    = 3;
   localparam int         BIT_IL0  = 4;
   localparam int         BIT_IL1  = 5;
   localparam int         BIT_I    = 6;
   localparam int         BIT_H    = 7;
   localparam int         BANK_LSB = 8;
   localparam logic [15:0] PSW_WMASK = 16'h1FFF;
   localparam logic [15:0] RST_VAL   = 16'h0000;
   // memory map borders
   localparam logic [15:0] IO_HI   = 16'h007F;
   localparam logic [15:0] DIR_HI  = 16'h00FF;
   localparam logic [15:0] GPR_LO  = 16'h0100;
   localparam logic [15:0] GPR_HI  = 16'h01FF;
   localparam logic [15:0] VEC_LO  = 16'hFFC0;
   localparam logic [7:0]  GPR_PAGE = 8'h01;
   // bank geometry
   localparam int BANKS    = 32;
   localparam int BANK_REGS = 8;
   // operations of the flag unit
   typedef enum logic [1:0] {
      CPC_OP_ADD, CPC_OP_SUB, CPC_OP_SHL, CPC_OP_SHR
   } cpc_op_t;
   // regions of the address space
   typedef enum logic [2:0] {
      CPC_RG_IO, CPC_RG_DIR, CPC_RG_GPR, CPC_RG_MEM, CPC_RG_VEC
   } cpc_region_t;
endpackage

/* File: hdl/cpc_alu_if.sv */
// carrier between core register file and flag unit
`timescale 1ns/10ps
interface cpc_alu_if;
   import cpc_pkg::*;
   logic [7:0] opa;   // first operand, accumulator low byte
   logic [7:0] opb;   // second operand, temp accumulator low byte
   cpc_op_t    op;    // selected operation
   logic       cin;   // carry shifted in
   logic [7:0] res;   // result byte
   logic       hf;    // half carry
   logic       nf;    // negative
   logic       zf;    // zero
   logic       vf;    // signed overflow
   logic       cf;    // carry or borrow
   modport core (output opa, opb, op, cin, input res, hf, nf, zf, vf, cf);
   modport alu  (input opa, opb, op, cin, output res, hf, nf, zf, vf, cf);
endinterface

/* File: hdl/cpc_flag_alu.sv */
// byte operation unit producing result and condition flags
`timescale 1ns/10ps
module cpc_flag_alu (
   cpc_alu_if.alu x
);
   import cpc_pkg::*;
   logic [8:0] sum9;  // add with carry out
   logic [8:0] dif9;  // subtract with borrow
   logic [4:0] sumh;  // low nibble add
   assign sum9 = {1'b0, x.opa} + {1'b0, x.opb};
   assign dif9 = {1'b0, x.opa} - {1'b0, x.opb};
   assign sumh = {1'b0, x.opa[3:0]} + {1'b0, x.opb[3:0]};
   // result and carry per operation
   always_comb begin
      x.res = sum9[7:0];
      x.cf  = sum9[8];
      x.hf  = sumh[4];
      x.vf  = (x.opa[7] == x.opb[7]) && (sum9[7] != x.opa[7]);
      unique case (x.op)
         CPC_OP_ADD: begin
            x.res = sum9[7:0];
         end
         CPC_OP_SUB: begin
            x.res = dif9[7:0];
            x.cf  = dif9[8];
            x.hf  = x.opa[3:0] < x.opb[3:0];
            x.vf  = (x.opa[7] != x.opb[7]) && (dif9[7] != x.opa[7]);
         end
         CPC_OP_SHL: begin
            x.res = {x.opa[6:0], x.cin};
            x.cf  = x.opa[7];
            x.hf  = 1'b0;
            x.vf  = 1'b0;
         end
         CPC_OP_SHR: begin
            x.res = {x.cin, x.opa[7:1]};
            x.cf  = x.opa[0];
            x.hf  = 1'b0;
            x.vf  = 1'b0;
         end
      endcase
   end
   assign x.nf = x.res[7];
   assign x.zf = (x.res == 8'h00);
endmodule

/* File: hdl/cpc_addr_map.sv */
// memory space region decode and bank register address
`timescale 1ns/10ps
module cpc_addr_map (
   input  wire logic [15:0]         probe,
   input  wire logic [4:0]          bank,
   input  wire logic [2:0]          sel,
   output cpc_pkg::cpc_region_t     region,
   output logic                     direct_ok,
   output logic [15:0]              gpr_addr
);
   import cpc_pkg::*;
   wire is_io  = probe <= IO_HI;
   wire is_dir = (probe > IO_HI) && (probe <= DIR_HI);
   wire is_gpr = (probe >= GPR_LO) && (probe <= GPR_HI);
   wire is_vec = probe >= VEC_LO;
   // region priority follows the map from the bottom up
   assign region = is_io  ? CPC_RG_IO  :
                   is_dir ? CPC_RG_DIR :
                   is_gpr ? CPC_RG_GPR :
                   is_vec ? CPC_RG_VEC : CPC_RG_MEM;
   // short direct mode reaches io and the fast ram page
   assign direct_ok = is_io | is_dir;
   // page one, bank bits, then register select
   assign gpr_addr = {GPR_PAGE, bank, sel};
endmodule

/* File: hdl/cpc_core_regs.sv */
// cpu core dedicated registers, flags and banked registers
// Overview of operation
// - low region decodes as io, direct reachable
// - ram 80h to ffh reachable by direct
// - register banks live at 100h to 1ffh
// - bank ram is never cleared by reset
// - top region from ffc0 is vector table
// - sixteen bit instruction pointer holds address
// - accumulator sixteen bits, byte ops low
// - second accumulator is other operand, low byte
// - index, extra pointer, stack registers sixteen bits
// - status word is bank high, flags low
// - bank address is page one, bank, select
// - half carry from nibble carry or borrow
// - interrupt enable gates, reset clears it
// - level field admits only higher priority
// - negative flag copies result msb
// - zero flag marks zero result
// - overflow flag marks signed overflow
// - carry from bit seven, shift out bit
// - thirty two banks of eight byte registers
`timescale 1ns/10ps
module cpc_core_regs (
   input  wire logic        core_clk,
   input  wire logic        resetn,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        irq_req,
   input  wire logic [1:0]  irq_req_level,
   output logic             irq_admit,
   output logic [4:0]       bank_select
);
   import cpc_pkg::*;

   // bus handshake state
   logic        ack_r;          // second cycle of an access
   logic [31:0] rdata_r;        // read data holding register
   // dedicated registers, index is word offset
   logic [15:0] dreg_r [NREG];
   // last operation started
   cpc_op_t     op_r;
   // address probe for the map decoder
   logic [15:0] probe_r;
   // registered interrupt admission
   logic        admit_r;
   // banked byte registers, deliberately without reset
   logic [7:0]  gpr_mem [BANKS*BANK_REGS];

   // decode of the current access
   wire         req     = avs_read | avs_write;
   wire         wr_go   = avs_write & ack_r;
   wire         rd_load = avs_read & ~ack_r;
   wire [2:0]   widx    = avs_address[4:2];
   wire         hit_d   = avs_address < OFF_ALU;
   wire         hit_alu = avs_address == OFF_ALU;
   wire         hit_prb = avs_address == OFF_PROBE;
   wire         hit_rgn = avs_address == OFF_REGN;
   wire         hit_gad = avs_address == OFF_GADR;
   wire         hit_gpr = (avs_address >= OFF_GPR) && (avs_address <= OFF_GEND);
   wire [2:0]   gsel    = avs_address[4:2];
   wire         alu_go  = wr_go & hit_alu;

   // views of the status word and accumulator
   wire [15:0]  psw     = dreg_r[IDX_PSW];
   wire [15:0]  acc     = dreg_r[IDX_ACC];
   wire [1:0]   il_code = {psw[BIT_IL1], psw[BIT_IL0]};
   wire [4:0]   bank    = psw[BANK_LSB +: 5];

   // map decoder outputs
   cpc_region_t region;
   logic        direct_ok;
   logic [15:0] gpr_addr;
   logic [15:0] gpr_bus_addr;

   // byte unit carrier
   cpc_alu_if   alu_x ();

   // waitrequest: one stall cycle for every access
   assign avs_waitrequest = req & ~ack_r;
   assign avs_readdata    = rdata_r;
   assign irq_admit       = admit_r;
   assign bank_select     = bank;

   // merge enabled byte lanes into a 16 bit word
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [15:0] wd,
                                           input logic [1:0]  be);
      merge16 = old;
      if (be[0]) begin
         merge16[7:0] = wd[7:0];
      end
      if (be[1]) begin
         merge16[15:8] = wd[15:8];
      end
   endfunction

   // level code to level number, 00 and 01 share level one
   function automatic logic [1:0] il_level(input logic [1:0] c);
      il_level = (c == 2'h0) ? 2'h1 : c;
   endfunction

   // region decode of the probe and bank address of a select
   cpc_addr_map u_map (
      .probe     (probe_r),
      .bank      (bank),
      .sel       (probe_r[2:0]),
      .region    (region),
      .direct_ok (direct_ok),
      .gpr_addr  (gpr_addr)
   );

   // same decoder logic for the bus window into the current bank
   cpc_addr_map u_bus_map (
      .probe     (16'h0000),
      .bank      (bank),
      .sel       (gsel),
      .region    (),
      .direct_ok (),
      .gpr_addr  (gpr_bus_addr)
   );

   // byte operations use the low bytes of both accumulators
   assign alu_x.opa = acc[7:0];
   assign alu_x.opb = dreg_r[2][7:0];
   assign alu_x.op  = cpc_op_t'(avs_writedata[1:0]);
   assign alu_x.cin = psw[BIT_C];

   cpc_flag_alu u_alu (
      .x (alu_x.alu)
   );

   // bus access phase toggles once per request
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req & ~ack_r;
      end
   end

   // read mux, unmapped words read as zero
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_d) begin
         rd_mux = {16'h0000, dreg_r[widx]};
      end else if (hit_alu) begin
         rd_mux = {30'h0000_0000, op_r};
      end else if (hit_prb) begin
         rd_mux = {16'h0000, probe_r};
      end else if (hit_rgn) begin
         rd_mux = {28'h000_0000, direct_ok, region};
      end else if (hit_gad) begin
         rd_mux = {16'h0000, gpr_addr};
      end else if (hit_gpr) begin
         rd_mux = {24'h00_0000, gpr_mem[gpr_bus_addr[7:0]]};
      end
   end

   // read data captured in the stall cycle, held afterwards
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rdata_r <= 32'h0000_0000;
      end else if (rd_load) begin
         rdata_r <= rd_mux;
      end
   end

   // status word after a byte operation
   logic [15:0] psw_alu;
   always_comb begin
      psw_alu        = psw;
      psw_alu[BIT_H] = alu_x.hf;
      psw_alu[BIT_N] = alu_x.nf;
      psw_alu[BIT_Z] = alu_x.zf;
      psw_alu[BIT_V] = alu_x.vf;
      psw_alu[BIT_C] = alu_x.cf;
   end

   // dedicated registers, one writer process each
   generate
      for (genvar i = 0; i < NREG; i++) begin : g_dreg
         localparam logic [2:0] IDX = 3'(i);
         logic [15:0] wmask;
         assign wmask = (IDX == IDX_PSW) ? PSW_WMASK : 16'hFFFF;
         always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
               // clears the enable bit among the rest
               dreg_r[i] <= RST_VAL;
            end else if (wr_go && hit_d && widx == IDX) begin
               dreg_r[i] <= merge16(dreg_r[i], avs_writedata[15:0],
                                    avs_byteenable[1:0]) & wmask;
            end else if (alu_go && IDX == IDX_ACC) begin
               // upper accumulator byte untouched by byte ops
               dreg_r[i] <= {dreg_r[i][15:8], alu_x.res};
            end else if (alu_go && IDX == IDX_PSW) begin
               dreg_r[i] <= psw_alu;
            end
         end
      end
   endgenerate

   // operation register and address probe
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         op_r    <= CPC_OP_ADD;
         probe_r <= RST_VAL;
      end else if (alu_go) begin
         op_r    <= alu_x.op;
      end else if (wr_go && hit_prb) begin
         probe_r <= merge16(probe_r, avs_writedata[15:0],
                            avs_byteenable[1:0]);
      end
   end

   // bank ram keeps whatever it held across reset
   always_ff @(posedge core_clk) begin
      if (wr_go && hit_gpr && avs_byteenable[0]) begin
         gpr_mem[gpr_bus_addr[7:0]] <= avs_writedata[7:0];
      end
   end

   // admission needs enable set and a strictly better level
   wire admit_nxt = irq_req && psw[BIT_I]
                    && (irq_req_level != 2'h0)
                    && (irq_req_level < il_level(il_code));

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         admit_r <= 1'b0;
      end else begin
         admit_r <= admit_nxt;
      end
   end

   // checks kept beside the logic
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   // reference add for flag checks
   wire [8:0] ref_sum = {1'b0, acc[7:0]} + {1'b0, dreg_r[2][7:0]};
   wire [4:0] ref_nib = {1'b0, acc[3:0]} + {1'b0, dreg_r[2][3:0]};
   wire       is_add  = alu_go && avs_writedata[1:0] == CPC_OP_ADD;

   a_wait_one_cycle: assert property (       // bus
      req && avs_waitrequest |=> !avs_waitrequest)
      else $error("waitrequest held too long");
   a_ip_full_write: assert property (
      wr_go && avs_address == OFF_IP && avs_byteenable[1:0] == 2'b11
      |=> dreg_r[0] == $past(avs_writedata[15:0]))
      else $error("instruction pointer write lost");
   a_acc_high_kept: assert property (
      alu_go |=> acc[15:8] == $past(acc[15:8]))
      else $error("byte op touched upper accumulator");
   a_add_carry_flag: assert property (
      is_add |=> psw[BIT_C] == $past(ref_sum[8]))
      else $error("carry flag wrong after add");
   a_add_half_flag: assert property (
      is_add |=> psw[BIT_H] == $past(ref_nib[4]))
      else $error("half carry wrong after add");
   a_zero_neg_flags: assert property (
      alu_go |=> psw[BIT_Z] == (acc[7:0] == 8'h00) && psw[BIT_N] == acc[7])
      else $error("zero or negative flag wrong");
   a_admit_needs_en: assert property (
      irq_admit |-> $past(psw[BIT_I]))
      else $error("interrupt admitted while disabled");
   a_level_three_block: assert property (
      il_code == 2'b11 && irq_req_level == 2'b11 |=> !irq_admit)
      else $error("equal level admitted");
   // arithmetic form, so a swapped or dropped field in the concatenation shows up
   a_bank_address: assert property (
      gpr_addr == GPR_LO + 16'({bank, probe_r[2:0]}))
      else $error("bank address malformed");

   c_read_done:  cover property (avs_read && !avs_waitrequest);
   c_add_carry:  cover property (is_add ##1 psw[BIT_C]);
   c_irq_admit:  cover property (irq_admit);
   c_bank_write: cover property (wr_go && hit_gpr && bank != 5'h00);

endmodule

/* File: test/cpc_core_regs_tb_top.sv */
// self-checking bench of the cpu core register block
`timescale 1ns/10ps
module cpc_core_regs_tb_top;
   import cpc_pkg::*;
   logic        core_clk = 1'b0;        // 25 MHz core clock
   logic        resetn = 1'b0;          // async reset, low active
   logic [7:0]  avs_address = 8'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        irq_req = 1'b0;
   logic [1:0]  irq_req_level = 2'h0;
   logic        irq_admit;
   logic [4:0]  bank_select;
   int          errors = 0;             // mismatches seen
   int          n_compared = 0;         // comparisons made
   // region probe table, expected {direct_ok, region} per entry
   logic [15:0] p_a [10] = '{16'h0000, 16'h007F, 16'h0080, 16'h00FF, 16'h0100,
                             16'h01FF, 16'h0200, 16'hFFBF, 16'hFFC0, 16'hFFFF};
   logic [39:0] p_e = 40'h4433229988;
   // byte op table: op, operands, carry in
   logic [17:0] t_op = {2'h3, 2'h3, 2'h2, 2'h1, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0};
   logic [7:0]  t_a [9] = '{8'h08, 8'h7F, 8'hFF, 8'h00, 8'h80, 8'h05, 8'h81, 8'h01, 8'h80};
   logic [7:0]  t_b [9] = '{8'h08, 8'h01, 8'h01, 8'h01, 8'h01, 8'h05, 8'h00, 8'h00, 8'h00};
   logic [8:0]  t_c = 9'h140;
   // expected admission, bit 4*level code + request level, enable set
   logic [15:0] adm_tab = 16'h6200;

   cpc_core_regs i_cpc_core_regs (
      .core_clk        (core_clk),
      .resetn          (resetn),
      .avs_address     (avs_address),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .avs_writedata   (avs_writedata),
      .avs_byteenable  (avs_byteenable),
      .avs_readdata    (avs_readdata),
      .avs_waitrequest (avs_waitrequest),
      .irq_req         (irq_req),
      .irq_req_level   (irq_req_level),
      .irq_admit       (irq_admit),
      .bank_select     (bank_select)
   );

   // free running clock, half period 20 ns
   always #20 core_clk = ~core_clk;

   // verdict and end of run, shared by watchdog and main sequence
   task automatic conclude;
      $display("compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one avalon access, request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
      @(posedge core_clk);
      avs_address    <= a;
      avs_write      <= wr;
      avs_read       <= ~wr;
      avs_writedata  <= d;
      avs_byteenable <= 4'hF;
      // read just after the edge, so these are the values the design sampled there
      do begin
         @(posedge core_clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] q;
      bus(1'b1, a, {16'h0, d}, q);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [15:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, {16'h0, e});
   endtask

   // expected {status word, result} of one byte op, bank and irq fields zero
   function automatic logic [15:0] alu_exp(input logic [1:0] op, input logic [7:0] a,
                                           input logic [7:0] b, input logic c);
      logic [8:0] r;
      logic       h;
      logic       v;
      r = 9'h0;
      h = 1'b0;
      v = 1'b0;
      case (op)
         2'h0: begin
            r = a + b;
            h = ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'hF;
            v = (a[7] == b[7]) && (r[7] != a[7]);
         end
         2'h1: begin
            r = {a < b, 8'(a - b)};
            h = a[3:0] < b[3:0];
            v = (a[7] != b[7]) && (r[7] != a[7]);
         end
         2'h2: r = {a[7], a[6:0], c};
         default: r = {a[0], c, a[7:1]};
      endcase
      return {h, 3'h0, r[7], r[7:0] == 8'h00, v, r[8], r[7:0]};
   endfunction

   // reset and re-reset, both resets held across several edges
   task automatic do_reset;
      resetn <= 1'b0;
      repeat (16) @(posedge core_clk);
      resetn <= 1'b1;
   endtask

   initial begin
      #(40 * 20000);
      errors++;
      conclude();
   end

   // main sequence
   initial begin
      logic [15:0] e;
      do_reset();
      for (int i = 0; i < 7; i++) rdc({i[5:0], 2'b00}, 16'h0000);
      chk(32'(bank_select), 32'h0);
      // every dedicated register below the status word holds all sixteen bits
      for (int i = 0; i < 6; i++) begin
         wr({i[5:0], 2'b00}, 16'hA5C0 | 16'(i));
         rdc({i[5:0], 2'b00}, 16'hA5C0 | 16'(i));
      end
      // status word top bits stay zero, bank pointer follows
      wr(OFF_PSW, 16'hFFFF);
      rdc(OFF_PSW, 16'h1FFF);
      chk(32'(bank_select), 32'h1F);
      // unmapped place reads zero and ignores writes
      wr(8'h34, 16'hFFFF);
      rdc(8'h34, 16'h0000);
      rdc(OFF_REGN, 16'h0008);
      // region decode across every border
      for (int i = 0; i < 10; i++) begin
         wr(OFF_PROBE, p_a[i]);
         rdc(OFF_REGN, {12'h0, p_e[4*i +: 4]});
      end
      // bank register address
      wr(OFF_PROBE, 16'h0005);
      wr(OFF_PSW, 16'h1500);
      rdc(OFF_GADR, 16'h01AD);
      // banks keep separate contents
      wr(OFF_PSW, 16'h0300);
      wr(8'h54, 16'h00A5);
      wr(OFF_PSW, 16'h1F00);
      wr(8'h54, 16'h005A);
      wr(OFF_PSW, 16'h0300);
      rdc(8'h54, 16'h00A5);
      wr(OFF_PSW, 16'h1F00);
      rdc(8'h54, 16'h005A);
      // byte ops with flags, high accumulator byte untouched
      for (int i = 0; i < 9; i++) begin
         e = alu_exp(t_op[2*i +: 2], t_a[i], t_b[i], t_c[i]);
         wr(OFF_ACC, {8'h3C, t_a[i]});
         wr(OFF_TACC, {8'h7E, t_b[i]});
         wr(OFF_PSW, {15'h0, t_c[i]});
         wr(OFF_ALU, {14'h0, t_op[2*i +: 2]});
         rdc(OFF_ACC, {8'h3C, e[7:0]});
         rdc(OFF_ALU, {14'h0, t_op[2*i +: 2]});
         rdc(OFF_PSW, {8'h00, e[15:8]});
      end
      // interrupt admission over all level codes, enable set
      for (int il = 0; il < 4; il++) begin
         wr(OFF_PSW, 16'h0040 | 16'(il << 4));
         for (int l = 0; l < 4; l++) begin
            @(posedge core_clk);
            irq_req       <= 1'b1;
            irq_req_level <= 2'(l);
            repeat (2) @(negedge core_clk);
            chk(32'(irq_admit), 32'(adm_tab[4*il + l]));
         end
      end
      // enable cleared blocks a level one request under level code three
      wr(OFF_PSW, 16'h0030);
      @(posedge core_clk);
      irq_req_level <= 2'h1;
      repeat (2) @(negedge core_clk);
      chk(32'(irq_admit), 32'h0);
      // second reset in mid run clears enable again
      wr(OFF_PSW, 16'h0070);
      wr(8'h40, 16'h00C3);
      do_reset();
      rdc(OFF_PSW, 16'h0000);
      rdc(8'h40, 16'h00C3);
      chk(32'(irq_admit), 32'h0);
      conclude();
   end
endmodule
